// *** rtl/lmd_ctrl.v ***
// Behaviour
// - one open bit and one short bit kept per LED position.
// - detect field going 00 to 01 or 10 starts fault capture.
// - LEDs turned off by dot scaling keep old fault bits.
// - pull select 0x00 disables all pulls; host writes it before detect.
// - each capture is one-shot; clear field to 00 before next trigger.
// - selectable pull-down per row (8) and pull-up per column (18).
// - pull resistor enabled only while its output is off.
// - rising edge of power-down pin resets serial interface.
// - all registers keep contents in software and hardware shutdown.
// - soft power-down bit 0 turns off all current sources.
// - register access continues in software shutdown.
// - pin low is hardware shutdown, analog off; pin high leaves it.
// - registers stay accessible during hardware shutdown.
`timescale 1ns/100ps
`include "lmd_defines.vh"

module lmd_ctrl #(
    parameter ROWS = 8,
    parameter COLS = 18,
    parameter ROW_CYC = `LMD_ROW_CYC,
    parameter [6:0] BUS_ADDR = `LMD_BUS_ADDR
) (
    input wire clock, // system clock
    input wire rst_b, // synchronous reset, active low
    input wire scl_in, // serial clock pin
    input wire sda_in, // serial data pin level
    output wire sda_out, // serial data drive value, always low
    output reg sda_oe_b_ff, // low while pulling data low
    input wire power_down_pin_n, // hardware shutdown pin, low = shutdown
    input wire [COLS-1:0] open_sense, // open comparators, current row
    input wire [COLS-1:0] short_sense, // short comparators, current row
    input wire [ROWS*COLS-1:0] dot_off, // dot scaling turns LED off
    input wire [COLS-1:0] col_pwm_on, // column on from pwm datapath
    output reg [ROWS-1:0] row_switch_output_ff, // row source enables
    output reg [COLS-1:0] column_sink_output_ff, // column sink enables
    output reg [ROWS-1:0] row_pulldown_en_ff, // row pull-down enables
    output reg [COLS-1:0] col_pullup_en_ff, // column pull-up enables
    output wire [3:0] row_pull_code, // row pull resistor select
    output wire [3:0] col_pull_code, // column pull resistor select
    output wire [7:0] global_current_level, // global current setting
    output reg analog_en_ff, // analog circuits enabled
    output wire detect_busy // capture in progress
);

localparam [6:0] ST_IDLE = 7'h01;
localparam [6:0] ST_ADDR = 7'h02;
localparam [6:0] ST_AACK = 7'h04;
localparam [6:0] ST_WR = 7'h08;
localparam [6:0] ST_WACK = 7'h10;
localparam [6:0] ST_RD = 7'h20;
localparam [6:0] ST_RACK = 7'h40;
localparam [4:0] CAP_ROWS = `LMD_DETECT_SCANS * ROWS;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

reg scl_s1_ff, scl_s2_ff, scl_s3_ff;
reg sda_s1_ff, sda_s2_ff, sda_s3_ff;
reg pd_s1_ff, pd_s2_ff, pd_s3_ff;

always @(posedge clock) begin
    if (!rst_b) begin
        scl_s1_ff <= 1'b1;
        scl_s2_ff <= 1'b1;
        scl_s3_ff <= 1'b1;
        sda_s1_ff <= 1'b1;
        sda_s2_ff <= 1'b1;
        sda_s3_ff <= 1'b1;
        pd_s1_ff <= 1'b0;
        pd_s2_ff <= 1'b0;
        pd_s3_ff <= 1'b0;
    end else begin
        scl_s1_ff <= scl_in;
        scl_s2_ff <= scl_s1_ff;
        scl_s3_ff <= scl_s2_ff;
        sda_s1_ff <= sda_in;
        sda_s2_ff <= sda_s1_ff;
        sda_s3_ff <= sda_s2_ff;
        pd_s1_ff <= power_down_pin_n;
        pd_s2_ff <= pd_s1_ff;
        pd_s3_ff <= pd_s2_ff;
    end
end

wire scl_rise = scl_s2_ff & ~scl_s3_ff;
wire scl_fall = ~scl_s2_ff & scl_s3_ff;
wire bus_start = scl_s2_ff & scl_s3_ff & ~sda_s2_ff & sda_s3_ff;
wire bus_stop = scl_s2_ff & scl_s3_ff & sda_s2_ff & ~sda_s3_ff;
wire pd_release = pd_s2_ff & ~pd_s3_ff;
wire hw_shutdown = ~pd_s2_ff;

////////////////////////////////////////////////////////////////////////////////
// registers and fault store

reg [7:0] cfg_ff, gcl_ff, pull_ff;
reg [ROWS*COLS-1:0] open_ff, short_ff;

assign global_current_level = gcl_ff;
assign row_pull_code = pull_ff[`LMD_PULL_ROW_MSB:`LMD_PULL_ROW_LSB];
assign col_pull_code = pull_ff[`LMD_PULL_COL_MSB:`LMD_PULL_COL_LSB];

// fault bytes: three per row, columns 0..7, 8..15, 16..17, upper bits zero
function [7:0] fault_byte;
    input [7:0] addr;
    input [ROWS*COLS-1:0] bits;
    integer k, r, b, i;
    begin
        fault_byte = 8'h00;
        k = addr - `LMD_REG_FLT_FIRST;
        r = k / 3;
        b = k % 3;
        for (i = 0; i < 8; i = i + 1) begin
            if (b * 8 + i < COLS) begin
                fault_byte[i] = bits[r * COLS + b * 8 + i];
            end
        end
    end
endfunction

function [7:0] reg_read;
    input [7:0] addr;
    begin
        if (addr == `LMD_REG_CFG) begin
            reg_read = cfg_ff;
        end else if (addr == `LMD_REG_GCL) begin
            reg_read = gcl_ff;
        end else if (addr == `LMD_REG_PULL) begin
            reg_read = pull_ff;
        end else if (addr >= `LMD_REG_FLT_FIRST && addr <= `LMD_REG_FLT_LAST) begin
            // short results shown when the short mode is selected
            if (cfg_ff[`LMD_CFG_FDT_MSB:`LMD_CFG_FDT_LSB] == `LMD_FDT_SHORT) begin
                reg_read = fault_byte(addr, short_ff);
            end else begin
                reg_read = fault_byte(addr, open_ff);
            end
        end else begin
            reg_read = 8'h00;
        end
    end
endfunction

// first bit on the wire for a read byte
function rd_msb;
    input [7:0] addr;
    reg [7:0] v;
    begin
        v = reg_read(addr);
        rd_msb = v[7];
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// serial slave

reg [6:0] st_ff;
reg [3:0] bit_cnt_ff;
reg [7:0] shift_ff, ptr_ff;
reg rw_ff, ptr_set_ff, nack_ff;
reg wr_en_ff;
reg [7:0] wr_addr_ff;

// write strobe registered: data byte stays in shift_ff through the ack slot
always @(posedge clock) begin
    wr_en_ff <= 1'b0;
    if (!rst_b) begin
        st_ff <= ST_IDLE;
        bit_cnt_ff <= 4'h0;
        shift_ff <= 8'h00;
        ptr_ff <= 8'h00;
        wr_addr_ff <= 8'h00;
        rw_ff <= 1'b0;
        ptr_set_ff <= 1'b0;
        nack_ff <= 1'b0;
        sda_oe_b_ff <= 1'b1;
    end else if (pd_release) begin
        // partial transfer dropped, wait for a new start
        st_ff <= ST_IDLE;
        bit_cnt_ff <= 4'h0;
        sda_oe_b_ff <= 1'b1;
    end else if (bus_start) begin
        st_ff <= ST_ADDR;
        bit_cnt_ff <= 4'h0;
        ptr_set_ff <= 1'b0;
        sda_oe_b_ff <= 1'b1;
    end else if (bus_stop) begin
        st_ff <= ST_IDLE;
        sda_oe_b_ff <= 1'b1;
    end else begin
        case (st_ff)
            ST_ADDR, ST_WR: begin
                if (scl_rise) begin
                    shift_ff <= {shift_ff[6:0], sda_s2_ff};
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                    if (st_ff == ST_ADDR) begin
                        if (shift_ff[7:1] == BUS_ADDR) begin
                            rw_ff <= shift_ff[0];
                            st_ff <= ST_AACK;
                            sda_oe_b_ff <= 1'b0;
                        end else begin
                            st_ff <= ST_IDLE;
                        end
                    end else begin
                        st_ff <= ST_WACK;
                        sda_oe_b_ff <= 1'b0;
                        if (!ptr_set_ff) begin
                            ptr_ff <= shift_ff;
                            ptr_set_ff <= 1'b1;
                        end else begin
                            wr_en_ff <= 1'b1;
                            wr_addr_ff <= ptr_ff;
                            ptr_ff <= ptr_ff + 8'h01;
                        end
                    end
                end
            end
            ST_AACK, ST_WACK: begin
                if (scl_fall) begin
                    bit_cnt_ff <= 4'h0;
                    if (st_ff == ST_AACK && rw_ff) begin
                        st_ff <= ST_RD;
                        shift_ff <= reg_read(ptr_ff);
                        sda_oe_b_ff <= rd_msb(ptr_ff);
                    end else begin
                        st_ff <= ST_WR;
                        sda_oe_b_ff <= 1'b1;
                    end
                end
            end
            ST_RD: begin
                if (scl_rise) begin
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                end else if (scl_fall) begin
                    if (bit_cnt_ff == 4'h8) begin
                        st_ff <= ST_RACK;
                        sda_oe_b_ff <= 1'b1;
                    end else begin
                        shift_ff <= {shift_ff[6:0], 1'b0};
                        sda_oe_b_ff <= shift_ff[6];
                    end
                end
            end
            ST_RACK: begin
                if (scl_rise) begin
                    nack_ff <= sda_s2_ff;
                end else if (scl_fall) begin
                    if (nack_ff) begin
                        st_ff <= ST_IDLE;
                    end else begin
                        st_ff <= ST_RD;
                        bit_cnt_ff <= 4'h0;
                        ptr_ff <= ptr_ff + 8'h01;
                        shift_ff <= reg_read(ptr_ff + 8'h01);
                        sda_oe_b_ff <= rd_msb(ptr_ff + 8'h01);
                    end
                end
            end
            default: begin
                st_ff <= ST_IDLE;
                sda_oe_b_ff <= 1'b1;
            end
        endcase
    end
end

assign sda_out = 1'b0;

////////////////////////////////////////////////////////////////////////////////
// register writes and detect trigger

reg [4:0] cap_left_ff;
wire [1:0] new_fdt = shift_ff[`LMD_CFG_FDT_MSB:`LMD_CFG_FDT_LSB];
wire [1:0] old_fdt = cfg_ff[`LMD_CFG_FDT_MSB:`LMD_CFG_FDT_LSB];
// a held nonzero field never retriggers; software must pass through 00
wire trigger = wr_en_ff && wr_addr_ff == `LMD_REG_CFG && old_fdt == `LMD_FDT_NONE
    && (new_fdt == `LMD_FDT_OPEN || new_fdt == `LMD_FDT_SHORT);

// no clear on shutdown: contents survive both modes
always @(posedge clock) begin
    if (!rst_b) begin
        cfg_ff <= `LMD_RST_CFG;
        gcl_ff <= `LMD_RST_GCL;
        pull_ff <= `LMD_RST_PULL;
    end else if (wr_en_ff) begin
        if (wr_addr_ff == `LMD_REG_CFG) begin
            cfg_ff <= shift_ff;
        end else if (wr_addr_ff == `LMD_REG_GCL) begin
            gcl_ff <= shift_ff;
        end else if (wr_addr_ff == `LMD_REG_PULL) begin
            pull_ff <= shift_ff;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// scanning, capture and output drive

reg [31:0] tick_ff;
reg [2:0] row_ff;
wire row_end = tick_ff == ROW_CYC - 1;
wire drive_on = cfg_ff[`LMD_CFG_SPD_BIT] & ~hw_shutdown;
reg [ROWS-1:0] row_on;
reg [COLS-1:0] col_on;
integer c, r;

assign detect_busy = cap_left_ff != 5'h00;

always @* begin
    for (r = 0; r < ROWS; r = r + 1) begin
        row_on[r] = drive_on && row_ff == r;
    end
    col_on = drive_on ? col_pwm_on : {COLS{1'b0}};
end

always @(posedge clock) begin
    if (!rst_b) begin
        tick_ff <= 32'h0;
        row_ff <= 3'h0;
        cap_left_ff <= 5'h00;
        open_ff <= {ROWS*COLS{1'b0}};
        short_ff <= {ROWS*COLS{1'b0}};
        row_switch_output_ff <= {ROWS{1'b0}};
        column_sink_output_ff <= {COLS{1'b0}};
        row_pulldown_en_ff <= {ROWS{1'b0}};
        col_pullup_en_ff <= {COLS{1'b0}};
        analog_en_ff <= 1'b0;
    end else begin
        tick_ff <= row_end ? 32'h0 : tick_ff + 32'h1;
        if (row_end) begin
            row_ff <= (row_ff == ROWS - 1) ? 3'h0 : row_ff + 3'h1;
        end
        // two full scans: every row captured twice
        if (trigger) begin
            cap_left_ff <= CAP_ROWS;
        end else if (row_end && detect_busy) begin
            cap_left_ff <= cap_left_ff - 5'h01;
            for (c = 0; c < COLS; c = c + 1) begin
                if (!dot_off[row_ff * COLS + c]) begin
                    if (old_fdt == `LMD_FDT_SHORT) begin
                        short_ff[row_ff * COLS + c] <= short_sense[c];
                    end else begin
                        open_ff[row_ff * COLS + c] <= open_sense[c];
                    end
                end
            end
        end
        analog_en_ff <= ~hw_shutdown;
        row_switch_output_ff <= row_on;
        column_sink_output_ff <= col_on;
        // resistors only on idle outputs, so no current through them
        row_pulldown_en_ff <= (row_pull_code != 4'h0) ? ~row_on : {ROWS{1'b0}};
        col_pullup_en_ff <= (col_pull_code != 4'h0) ? ~col_on : {COLS{1'b0}};
    end
end

endmodule // lmd_ctrl

// *** rtl/lmd_defines.vh ***
`ifndef LMD_DEFINES_VH
`define LMD_DEFINES_VH

// register offsets
`define LMD_REG_CFG 8'h00
`define LMD_REG_GCL 8'h01
`define LMD_REG_PULL 8'h02
`define LMD_REG_FLT_FIRST 8'h03
`define LMD_REG_FLT_LAST 8'h1A

// configuration fields
`define LMD_CFG_SPD_BIT 0
`define LMD_CFG_FDT_LSB 1
`define LMD_CFG_FDT_MSB 2
`define LMD_FDT_NONE 2'h0
`define LMD_FDT_OPEN 2'h1
`define LMD_FDT_SHORT 2'h2

// pull select fields
`define LMD_PULL_ROW_LSB 0
`define LMD_PULL_ROW_MSB 3
`define LMD_PULL_COL_LSB 4
`define LMD_PULL_COL_MSB 7
`define LMD_PULL_OFF 8'h00

// reset values
`define LMD_RST_CFG 8'h00
`define LMD_RST_GCL 8'h00
`define LMD_RST_PULL 8'h00

// timing
`define LMD_CLK_KHZ 250000
`define LMD_ROW_TIME_NS 33000
// scaled in two steps so the product stays inside 32 bits
`define LMD_ROW_CYC ((`LMD_ROW_TIME_NS * (`LMD_CLK_KHZ / 1000)) / 1000)
`define LMD_DETECT_SCANS 2

// serial bus address, value arbitrary
`define LMD_BUS_ADDR 7'h50

`endif

// *** sim/lmd_ctrl_checker.sv ***
`timescale 1ns/100ps
module lmd_ctrl_checker #(
    parameter ROWS = 8,
    parameter COLS = 18
) (
    input wire logic clock, // system clock
    input wire logic rst_b, // sync reset, active low
    input wire logic power_down_pin_n, // shutdown pin
    input wire logic sda_oe_b_ff, // data pull enable, low drives
    input wire logic [COLS-1:0] col_pwm_on, // column requests
    input wire logic [ROWS-1:0] row_switch_output_ff, // row drive
    input wire logic [COLS-1:0] column_sink_output_ff, // column drive
    input wire logic [ROWS-1:0] row_pulldown_en_ff, // row pulls
    input wire logic [COLS-1:0] col_pullup_en_ff, // column pulls
    input wire logic [3:0] row_pull_code, // row pull select
    input wire logic [3:0] col_pull_code, // column pull select
    input wire logic analog_en_ff, // analog enable
    input wire logic detect_busy // capture running
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // five samples cover the two-stage pin synchroniser plus the output register
    AST_HW_OFF: assert property (!power_down_pin_n [*5] |-> !analog_en_ff)
        else $error("analog on in hardware shutdown");
    AST_HW_ON: assert property (power_down_pin_n [*5] |-> analog_en_ff)
        else $error("analog off with pin high");
    AST_BLANK: assert property (!power_down_pin_n [*5] |-> column_sink_output_ff == '0)
        else $error("columns driven in shutdown");
    AST_ROW_PD: assert property ((row_pulldown_en_ff & row_switch_output_ff) == '0)
        else $error("row pull on while row driven");
    AST_COL_PU: assert property ((col_pullup_en_ff & column_sink_output_ff) == '0)
        else $error("column pull on while column driven");
    AST_PULL_OFF: assert property (row_pull_code == 4'h0 && col_pull_code == 4'h0 |=>
        row_pulldown_en_ff == '0 && col_pullup_en_ff == '0)
        else $error("pulls on with zero select");
    AST_ROW_PULL: assert property (row_pull_code != 4'h0 && $stable(row_pull_code) &&
        $stable(row_switch_output_ff) |-> row_pulldown_en_ff == ~row_switch_output_ff)
        else $error("row pull not on idle row");
    AST_COL_PULL: assert property (col_pull_code != 4'h0 && $stable(col_pull_code) &&
        $stable(column_sink_output_ff) |-> col_pullup_en_ff == ~column_sink_output_ff)
        else $error("column pull not on idle column");
    AST_SINK_SRC: assert property ((column_sink_output_ff & ~$past(col_pwm_on)) == '0)
        else $error("column driven without request");
    AST_BUSY_HOLD: assert property ($rose(detect_busy) |-> detect_busy [*8])
        else $error("capture ended early");
    AST_SER_RST: assert property ($rose(power_down_pin_n) |-> ##5 sda_oe_b_ff [*8])
        else $error("serial port active after pin rise");
endmodule // lmd_ctrl_checker

bind lmd_ctrl lmd_ctrl_checker #(.ROWS(ROWS), .COLS(COLS)) u_lmd_ctrl_checker (
    .clock(clock), .rst_b(rst_b), .power_down_pin_n(power_down_pin_n),
    .sda_oe_b_ff(sda_oe_b_ff), .col_pwm_on(col_pwm_on),
    .row_switch_output_ff(row_switch_output_ff), .column_sink_output_ff(column_sink_output_ff),
    .row_pulldown_en_ff(row_pulldown_en_ff), .col_pullup_en_ff(col_pullup_en_ff),
    .row_pull_code(row_pull_code), .col_pull_code(col_pull_code),
    .analog_en_ff(analog_en_ff), .detect_busy(detect_busy)
);

// *** sim/lmd_host.sv ***
`timescale 1ns/100ps
module lmd_host (
    output logic scl, // serial clock, 32 ns bit time
    output logic sda_h, // host data, 0 pulls low
    input wire logic sda // resolved data line
);
    // clock stands high and data released outside frames
    initial begin
        scl = 1'b1;
        sda_h = 1'b1;
    end
    // data moves mid-low, sampled mid-high: leaves room for the device's synchroniser
    task automatic bitx(input logic b, output logic q);
        scl = 1'b0;
        #8 sda_h = b;
        #8 scl = 1'b1;
        #8 q = sda;
        #8;
    endtask
    task automatic start;
        scl = 1'b0;
        #8 sda_h = 1'b1;
        #8 scl = 1'b1;
        #16 sda_h = 1'b0;
        #16;
    endtask
    task automatic stop;
        scl = 1'b0;
        #8 sda_h = 1'b0;
        #8 scl = 1'b1;
        #16 sda_h = 1'b1;
        #16;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        logic k;
        start();
        wbyte(8'hA0, k);
        wbyte(a, k);
        wbyte(d, k);
        stop();
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        logic k;
        start();
        wbyte(8'hA0, k);
        wbyte(a, k);
        start();
        wbyte(8'hA1, k);
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(1'b1, k);
        stop();
    endtask
endmodule // lmd_host

// *** sim/test_led_matrix_diag_shutdown_ctrl.sv ***
`timescale 1ns/100ps
module test_led_matrix_diag_shutdown_ctrl;
    localparam int RC = 16;
    logic clock, rst_b, power_down_pin_n, scl, sda_h, sda_oe_b_ff, sda_out;
    logic analog_en_ff, detect_busy, k;
    logic [17:0] open_sense, short_sense, col_pwm_on, column_sink_output_ff, col_pullup_en_ff;
    logic [7:0] row_switch_output_ff, row_pulldown_en_ff, global_current_level, d;
    logic [3:0] row_pull_code, col_pull_code;
    logic [143:0] dot_off;
    wire logic sda;
    int mismatches = 0;
    int n_checks = 0;
    // rows: offset, write value, value read back
    logic [23:0] tbl [5] = '{24'h012020, 24'h023131, 24'h1B5500, 24'h03FF00, 24'h000000};
    assign sda = sda_h & (sda_oe_b_ff | sda_out);
    lmd_host u_lmd_host (.scl(scl), .sda_h(sda_h), .sda(sda));
    lmd_ctrl #(.ROW_CYC(RC)) u_lmd_ctrl (
        .clock(clock), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_b_ff(sda_oe_b_ff), .power_down_pin_n(power_down_pin_n),
        .open_sense(open_sense), .short_sense(short_sense), .dot_off(dot_off),
        .col_pwm_on(col_pwm_on), .row_switch_output_ff(row_switch_output_ff),
        .column_sink_output_ff(column_sink_output_ff), .row_pulldown_en_ff(row_pulldown_en_ff),
        .col_pullup_en_ff(col_pullup_en_ff), .row_pull_code(row_pull_code),
        .col_pull_code(col_pull_code), .global_current_level(global_current_level),
        .analog_en_ff(analog_en_ff), .detect_busy(detect_busy)
    );
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [17:0] e, input logic [17:0] s, input string n);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        u_lmd_host.rreg(a, d);
        chk(e, d, "read");
    endtask
    task results;
        if (mismatches == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic waitdet;
        int n;
        n = 0;
        while (detect_busy !== 1'b0 && n < 2000) begin
            cyc(1);
            n++;
        end
        if (n == 2000) begin
            mismatches++;
            results();
        end
        cyc(16 * RC);
    endtask
    ////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        power_down_pin_n = 1'b1;
        open_sense = '0;
        short_sense = '0;
        col_pwm_on = '0;
        dot_off = '0;
        cyc(2);
        rst_b = 1'b1;
        cyc(8);
        foreach (tbl[i]) begin
            u_lmd_host.wreg(tbl[i][23:16], tbl[i][15:8]);
            rd(tbl[i][23:16], tbl[i][7:0]);
        end
        cyc(4);
        chk(8'h20, global_current_level, "gcl");
        chk(4'h1, row_pull_code, "row_code");
        chk(4'h3, col_pull_code, "col_code");
        chk(8'hFF, row_pulldown_en_ff, "row_pd");
        chk(18'h3FFFF, col_pullup_en_ff, "col_pu");
        chk(0, row_switch_output_ff, "rows");
        col_pwm_on = '1;
        u_lmd_host.wreg(8'h00, 8'h01);
        cyc(4 * RC);
        chk(18'h3FFFF, column_sink_output_ff, "cols");
        chk(0, col_pullup_en_ff, "col_pu");
        chk(1, $countones(row_switch_output_ff), "rows");
        u_lmd_host.wreg(8'h02, 8'h00);
        u_lmd_host.wreg(8'h01, 8'h0F);
        power_down_pin_n = 1'b0;
        cyc(8);
        chk(0, analog_en_ff, "analog");
        chk(0, column_sink_output_ff, "cols");
        chk(0, row_pulldown_en_ff, "row_pd");
        u_lmd_host.wreg(8'h01, 8'h40);
        rd(8'h00, 8'h01);
        rd(8'h01, 8'h40);
        power_down_pin_n = 1'b1;
        cyc(8);
        chk(1, analog_en_ff, "analog");
        open_sense = '1;
        dot_off[0] = 1'b1;
        u_lmd_host.wreg(8'h00, 8'h03);
        chk(1, detect_busy, "busy");
        waitdet();
        rd(8'h03, 8'hFE);
        rd(8'h05, 8'h03);
        rd(8'h1A, 8'h03);
        u_lmd_host.wreg(8'h00, 8'h05);
        chk(0, detect_busy, "busy");
        short_sense = 18'h00001;
        u_lmd_host.wreg(8'h00, 8'h01);
        u_lmd_host.wreg(8'h00, 8'h05);
        waitdet();
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h00);
        rd(8'h06, 8'h01);
        // pin pulse in mid-byte while the clock stands still
        u_lmd_host.start();
        u_lmd_host.wbyte(8'hA0, k);
        chk(1, k, "ack");
        repeat (4) u_lmd_host.bitx(1'b0, k);
        power_down_pin_n = 1'b0;
        cyc(8);
        power_down_pin_n = 1'b1;
        cyc(8);
        u_lmd_host.wbyte(8'h01, k);
        chk(0, k, "ack");
        u_lmd_host.stop();
        rd(8'h01, 8'h40);
        results();
    end
endmodule // test_led_matrix_diag_shutdown_ctrl
